// file: hcc_pkg.sv
// constants, types and register layout of the hysteresis current chopper
package hcc_pkg;

  // ==========================================================
  // register map (byte addresses on the AXI4-Lite slave)
  localparam int          ADDR_W    = 8;
  localparam logic [7:0]  ADDR_CONF = 8'h00;
  localparam logic [7:0]  ADDR_STAT = 8'h04;
  localparam logic [31:0] CONF_RST  = 32'h0000_0000;
  localparam logic [31:0] CONF_MASK = 32'h0000_3FFF;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================================
  // configuration word, bit 0 at the right
  typedef struct packed {
    logic [17:0] rsvd;
    logic [1:0]  blank_time_select;
    logic        const_off_mode;
    logic [3:0]  hyst_end_value;
    logic [2:0]  hyst_start_offset;
    logic [3:0]  off_time_setting;
  } hcc_cfg_t;

  // status word as read back by software
  typedef struct packed {
    logic [20:0] rsvd;
    logic        cmp_level;
    logic        blanking;
    logic [2:0]  phase;
    logic [5:0]  hyst_value;
  } hcc_stat_t;

  // bridge drive outputs travel together
  typedef struct packed {
    logic on;
    logic slow;
    logic fast;
  } hcc_bridge_t;

  // ==========================================================
  // chopper phases
  typedef enum logic [2:0] {
    PH_OFF,
    PH_ON,
    PH_SLOW1,
    PH_FAST,
    PH_SLOW2
  } hcc_phase_t;

  // ==========================================================
  // timing in system clock cycles; END_BIAS and HYST_ZERO are hysteresis values
  localparam logic [9:0] SLOW_BASE   = 10'h00C;  // 12 clocks
  localparam logic [9:0] SLOW_STEP   = 10'h020;  // 32 clocks per step
  localparam logic [3:0] DEC_DIV_MAX = 4'hF;     // one step every 16 clocks
  localparam logic [5:0] BLANK_0     = 6'h10;    // 16
  localparam logic [5:0] BLANK_1     = 6'h18;    // 24
  localparam logic [5:0] BLANK_2     = 6'h24;    // 36
  localparam logic [5:0] BLANK_3     = 6'h36;    // 54
  localparam logic [5:0] END_BIAS    = 6'h03;
  localparam logic [5:0] HYST_ZERO   = 6'h00;

endpackage : hcc_pkg

// file: hcc_sync.sv
// two-stage synchroniser for the comparator pin
`timescale 1ns/10ps
module hcc_sync (
  input  wire logic CLOCK,
  input  wire logic RST,
  input  wire logic D,
  output logic      Q
);

  logic meta_r;

  // ==========================================================
  // first stage feeds only the second
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      meta_r <= 1'b0;
      Q      <= 1'b0;
    end else begin
      meta_r <= D;
      Q      <= meta_r;
    end
  end

endmodule : hcc_sync

// file: hcc_chopper.sv
// hysteresis current chopper for one coil with AXI4-Lite configuration
//
// Behaviour
// - hysteresis mode cycles on, slow decay, fast decay, second slow decay.
// - hysteresis drops by one step every 16 clocks during a cycle.
// - cycle start loads start plus end; decrement stops at the end value.
// - 3-bit start offset codes 0..7 add 1..8 above the end value.
// - 4-bit end code decodes as code minus 3, range -3..12.
// - start and end both zero means hysteresis is zero and off.
// - slow decay lasts 12 plus 32 times off time clocks, timer ended.
// - comparator ignored while blanking; on and fast decay exit on it only after blanking ends.
// - on phase ends when comparator says current reached target.
// - off time zero switches every bridge transistor off, freewheeling.
// - blank select 0..3 gives 16, 24, 36, 54 clocks.
// - mode bit clear selects hysteresis chopper, set selects constant off time.
`timescale 1ns/10ps
module hcc_chopper (
  input  wire logic                      CLOCK,
  input  wire logic                      RST,
  input  wire logic [hcc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic                      S_AXI_AWVALID,
  output logic                           S_AXI_AWREADY,
  input  wire logic [31:0]               S_AXI_WDATA,
  input  wire logic [3:0]                S_AXI_WSTRB,
  input  wire logic                      S_AXI_WVALID,
  output logic                           S_AXI_WREADY,
  output logic [1:0]                     S_AXI_BRESP,
  output logic                           S_AXI_BVALID,
  input  wire logic                      S_AXI_BREADY,
  input  wire logic [hcc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic                      S_AXI_ARVALID,
  output logic                           S_AXI_ARREADY,
  output logic [31:0]                    S_AXI_RDATA,
  output logic [1:0]                     S_AXI_RRESP,
  output logic                           S_AXI_RVALID,
  input  wire logic                      S_AXI_RREADY,
  input  wire logic                      CMP_IN,
  output logic [5:0]                     HYST_OUT,
  output logic                           BLANK_OUT,
  output hcc_pkg::hcc_bridge_t           BRIDGE
);

  // ==========================================================
  // declarations
  logic                      cmp_s;
  hcc_pkg::hcc_cfg_t         cfg_r,     cfg_nxt;
  logic                      aw_hold_r, aw_hold_nxt;
  logic [hcc_pkg::ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic                      w_hold_r,  w_hold_nxt;
  logic [31:0]               w_data_r,  w_data_nxt;
  logic [3:0]                w_strb_r,  w_strb_nxt;
  logic                      bvalid_r,  bvalid_nxt;
  logic [1:0]                bresp_r,   bresp_nxt;
  logic                      rvalid_r,  rvalid_nxt;
  logic [31:0]               rdata_r,   rdata_nxt;
  logic [1:0]                rresp_r,   rresp_nxt;
  hcc_pkg::hcc_phase_t       phase_r,   phase_nxt;
  logic [9:0]                timer_r,   timer_nxt;
  logic [5:0]                blank_r,   blank_nxt;
  logic [3:0]                div_r,     div_nxt;
  logic [5:0]                hyst_r,    hyst_nxt;
  hcc_pkg::hcc_bridge_t      bridge_r,  bridge_nxt;
  logic [5:0]                eff_end;
  logic [5:0]                eff_start;
  logic [5:0]                blank_len;
  logic [9:0]                slow_len;
  logic                      hyst_off;
  hcc_pkg::hcc_stat_t        stat;

  // comparator comes from the analog side, so it is synchronised
  hcc_sync u_cmp_sync (
    .CLOCK (CLOCK),
    .RST   (RST),
    .D     (CMP_IN),
    .Q     (cmp_s)
  );

  // ==========================================================
  // decoded settings
  always_comb begin
    hyst_off  = (cfg_r.hyst_start_offset == 3'h0) && (cfg_r.hyst_end_value == 4'h0);
    eff_end   = hyst_off ? hcc_pkg::HYST_ZERO
                         : 6'({2'b00, cfg_r.hyst_end_value}) - hcc_pkg::END_BIAS;
    eff_start = hyst_off ? hcc_pkg::HYST_ZERO
                         : eff_end + 6'({3'b000, cfg_r.hyst_start_offset}) + 6'h01;
    slow_len  = hcc_pkg::SLOW_BASE + 10'(hcc_pkg::SLOW_STEP * cfg_r.off_time_setting);
    case (cfg_r.blank_time_select)
      2'h0:    blank_len = hcc_pkg::BLANK_0;
      2'h1:    blank_len = hcc_pkg::BLANK_1;
      2'h2:    blank_len = hcc_pkg::BLANK_2;
      default: blank_len = hcc_pkg::BLANK_3;
    endcase
  end

  // ==========================================================
  // chopper sequencer: next state
  // slow timer loads length minus one; blank counter loads the full length so masking lasts all of it
  always_comb begin
    phase_nxt  = phase_r;
    timer_nxt  = (timer_r != 10'h000) ? timer_r - 10'h001 : timer_r;
    blank_nxt  = (blank_r != 6'h00) ? blank_r - 6'h01 : blank_r;
    div_nxt    = div_r + 4'h1;
    hyst_nxt   = hyst_r;
    // step down, clamped at the end value (signed compare)
    if (div_r == hcc_pkg::DEC_DIV_MAX && $signed(hyst_r) > $signed(eff_end)) begin
      hyst_nxt = hyst_r - 6'h01;
    end
    case (phase_r)
      hcc_pkg::PH_OFF: begin
        div_nxt = 4'h0;
        if (cfg_r.off_time_setting != 4'h0) begin
          phase_nxt = hcc_pkg::PH_ON;
          blank_nxt = blank_len;
          hyst_nxt  = eff_start;
        end
      end
      hcc_pkg::PH_ON: begin
        // comparator only trusted once blanking has run out
        if (blank_r == 6'h00 && cmp_s) begin
          if (cfg_r.const_off_mode) begin
            phase_nxt = hcc_pkg::PH_FAST;
            blank_nxt = blank_len;
          end else begin
            phase_nxt = hcc_pkg::PH_SLOW1;
            timer_nxt = slow_len - 10'h001;
          end
        end
      end
      hcc_pkg::PH_SLOW1: begin
        if (timer_r == 10'h000) begin
          phase_nxt = hcc_pkg::PH_FAST;
          blank_nxt = blank_len;
        end
      end
      hcc_pkg::PH_FAST: begin
        // threshold is lowered by HYST_OUT outside, so low means below target minus hysteresis
        if (blank_r == 6'h00 && !cmp_s) begin
          phase_nxt = hcc_pkg::PH_SLOW2;
          timer_nxt = slow_len - 10'h001;
        end
      end
      hcc_pkg::PH_SLOW2: begin
        if (timer_r == 10'h000) begin
          phase_nxt = hcc_pkg::PH_ON;
          blank_nxt = blank_len;
          hyst_nxt  = eff_start;
          div_nxt   = 4'h0;
        end
      end
      default: phase_nxt = hcc_pkg::PH_OFF;
    endcase
    // off time zero aborts any phase at once
    if (cfg_r.off_time_setting == 4'h0) begin
      phase_nxt = hcc_pkg::PH_OFF;
      hyst_nxt  = hcc_pkg::HYST_ZERO;
    end
    bridge_nxt.on   = (phase_nxt == hcc_pkg::PH_ON);
    bridge_nxt.fast = (phase_nxt == hcc_pkg::PH_FAST);
    bridge_nxt.slow = (phase_nxt == hcc_pkg::PH_SLOW1) || (phase_nxt == hcc_pkg::PH_SLOW2);
  end

  // chopper sequencer: registers
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      phase_r  <= hcc_pkg::PH_OFF;
      timer_r  <= 10'h000;
      blank_r  <= 6'h00;
      div_r    <= 4'h0;
      hyst_r   <= hcc_pkg::HYST_ZERO;
      bridge_r <= '0;
    end else begin
      phase_r  <= phase_nxt;
      timer_r  <= timer_nxt;
      blank_r  <= blank_nxt;
      div_r    <= div_nxt;
      hyst_r   <= hyst_nxt;
      bridge_r <= bridge_nxt;
    end
  end

  assign BRIDGE    = bridge_r;
  assign HYST_OUT  = hyst_r;
  assign BLANK_OUT = (blank_r != 6'h00) && (phase_r == hcc_pkg::PH_ON || phase_r == hcc_pkg::PH_FAST);

  // ==========================================================
  // status word
  always_comb begin
    stat            = '0;
    stat.hyst_value = hyst_r;
    stat.phase      = phase_r;
    stat.blanking   = BLANK_OUT;
    stat.cmp_level  = cmp_s;
  end

  // ==========================================================
  // AXI4-Lite slave: next state
  // address and data may come in either order; both are held until paired
  always_comb begin
    cfg_nxt     = cfg_r;
    aw_hold_nxt = aw_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_hold_nxt  = w_hold_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_hold_nxt = 1'b1;
      w_data_nxt = S_AXI_WDATA;
      w_strb_nxt = S_AXI_WSTRB;
    end
    if (bvalid_r && S_AXI_BREADY) begin
      bvalid_nxt = 1'b0;
    end
    // pair complete: commit on the following edge's view
    if (aw_hold_r && w_hold_r && !bvalid_r) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      if (aw_addr_r[hcc_pkg::ADDR_W-1:2] == hcc_pkg::ADDR_CONF[hcc_pkg::ADDR_W-1:2]) begin
        for (int i = 0; i < 4; i++) begin
          if (w_strb_r[i]) begin
            cfg_nxt[i*8 +: 8] = w_data_r[i*8 +: 8];
          end
        end
        cfg_nxt   = cfg_nxt & hcc_pkg::CONF_MASK;
        bresp_nxt = hcc_pkg::RESP_OKAY;
      end else if (aw_addr_r[hcc_pkg::ADDR_W-1:2] == hcc_pkg::ADDR_STAT[hcc_pkg::ADDR_W-1:2]) begin
        bresp_nxt = hcc_pkg::RESP_OKAY; // status is read only, write ignored
      end else begin
        bresp_nxt = hcc_pkg::RESP_SLVERR;
      end
    end
    if (rvalid_r && S_AXI_RREADY) begin
      rvalid_nxt = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_nxt = 1'b1;
      if (S_AXI_ARADDR[hcc_pkg::ADDR_W-1:2] == hcc_pkg::ADDR_CONF[hcc_pkg::ADDR_W-1:2]) begin
        rdata_nxt = cfg_r;
        rresp_nxt = hcc_pkg::RESP_OKAY;
      end else if (S_AXI_ARADDR[hcc_pkg::ADDR_W-1:2] == hcc_pkg::ADDR_STAT[hcc_pkg::ADDR_W-1:2]) begin
        rdata_nxt = stat;
        rresp_nxt = hcc_pkg::RESP_OKAY;
      end else begin
        rdata_nxt = 32'h0000_0000;
        rresp_nxt = hcc_pkg::RESP_SLVERR;
      end
    end
  end

  // AXI4-Lite slave: registers
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      cfg_r     <= hcc_pkg::CONF_RST;
      aw_hold_r <= 1'b0;
      aw_addr_r <= '0;
      w_hold_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= hcc_pkg::RESP_OKAY;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= hcc_pkg::RESP_OKAY;
    end else begin
      cfg_r     <= cfg_nxt;
      aw_hold_r <= aw_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_hold_r  <= w_hold_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // ready is withheld while a half is parked or a response is pending
  assign S_AXI_AWREADY = !aw_hold_r && !bvalid_r;
  assign S_AXI_WREADY  = !w_hold_r && !bvalid_r;
  assign S_AXI_BVALID  = bvalid_r;
  assign S_AXI_BRESP   = bresp_r;
  assign S_AXI_ARREADY = !rvalid_r;
  assign S_AXI_RVALID  = rvalid_r;
  assign S_AXI_RDATA   = rdata_r;
  assign S_AXI_RRESP   = rresp_r;

endmodule : hcc_chopper

// file: hcc_coil_model.sv
// coil current and comparator model facing the bridge outputs
`timescale 1ns/10ps
module hcc_coil_model (
  input  wire logic                 CLOCK,
  input  wire logic                 RST,
  input  wire hcc_pkg::hcc_bridge_t BRIDGE,
  input  wire logic [3:0]           RATE,
  input  wire logic [5:0]           HYST,
  output logic                      CMP_IN
);
  logic [7:0] cur_r;
  logic [7:0] thr;

  // ==========================================================
  // coil current
  // rises while driven, falls in fast decay, holds in slow decay; rate sets the slope
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      cur_r <= 8'h00;
    end else if (BRIDGE.on && cur_r < 8'hC0) begin
      cur_r <= cur_r + {4'h0, RATE};
    end else if (BRIDGE.fast && cur_r > 8'h0F) begin
      cur_r <= cur_r - {4'h0, RATE};
    end
  end

  // target at quarter scale (0x40); in fast decay the threshold sits the signed hysteresis below it
  assign thr    = BRIDGE.fast ? (8'h40 - {{2{HYST[5]}}, HYST}) : 8'h40;
  assign CMP_IN = (cur_r >= thr);
endmodule : hcc_coil_model

// file: hcc_chopper_sva.sv
// port assertions for the hysteresis current chopper
`timescale 1ns/10ps
module hcc_chopper_sva (
  input wire logic                 CLOCK,
  input wire logic                 RST,
  input wire logic                 S_AXI_ARVALID,
  input wire logic                 S_AXI_ARREADY,
  input wire logic                 S_AXI_RVALID,
  input wire logic                 S_AXI_RREADY,
  input wire logic [31:0]          S_AXI_RDATA,
  input wire logic                 S_AXI_BVALID,
  input wire logic                 S_AXI_BREADY,
  input wire logic [1:0]           S_AXI_BRESP,
  input wire logic [5:0]           HYST_OUT,
  input wire logic                 BLANK_OUT,
  input wire hcc_pkg::hcc_bridge_t BRIDGE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  // ==========================================================
  // bridge sequencing
  a_bridge_onehot: assert property ($onehot0(BRIDGE)) else $error("two bridge phases at once");
  a_slow_entry: assert property ($rose(BRIDGE.slow) |-> $past(BRIDGE.on) || $past(BRIDGE.fast))
    else $error("slow decay entered from wrong phase");
  a_slow_length: assert property ($fell(BRIDGE.slow) && BRIDGE != 3'h0 |-> $past(BRIDGE.slow, 8))
    else $error("slow decay too short");
  // ==========================================================
  // blanking, the comparator is blind here
  a_blank_on: assert property ($rose(BRIDGE.on) |-> BLANK_OUT) else $error("no blanking at on entry");
  a_blank_fast: assert property ($rose(BRIDGE.fast) |-> (BLANK_OUT || BRIDGE == 3'h0)[*8])
    else $error("fast decay blanking too short");
  a_on_blanked: assert property (BRIDGE.on && BLANK_OUT |=> BRIDGE.on || BRIDGE == 3'h0)
    else $error("on phase ended while blanking");
  a_blank_phase: assert property (BLANK_OUT |-> BRIDGE.on || BRIDGE.fast)
    else $error("blanking outside on or fast decay");
  // ==========================================================
  // hysteresis decrement in the decay phases
  a_hyst_step: assert property ($changed(HYST_OUT) && (BRIDGE.slow || BRIDGE.fast)
    |-> HYST_OUT == $past(HYST_OUT) - 6'h01) else $error("hysteresis step not one");
  a_hyst_gap: assert property ($changed(HYST_OUT) && (BRIDGE.slow || BRIDGE.fast)
    |=> ($stable(HYST_OUT) || BRIDGE.on || BRIDGE == 3'h0)[*8]) else $error("hysteresis steps too close");
  // ==========================================================
  // register bus answers
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("late read data");
  a_read_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  a_write_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
endmodule : hcc_chopper_sva

bind hcc_chopper hcc_chopper_sva u_hcc_chopper_sva (
  .CLOCK         (CLOCK),
  .RST           (RST),
  .S_AXI_ARVALID (S_AXI_ARVALID),
  .S_AXI_ARREADY (S_AXI_ARREADY),
  .S_AXI_RVALID  (S_AXI_RVALID),
  .S_AXI_RREADY  (S_AXI_RREADY),
  .S_AXI_RDATA   (S_AXI_RDATA),
  .S_AXI_BVALID  (S_AXI_BVALID),
  .S_AXI_BREADY  (S_AXI_BREADY),
  .S_AXI_BRESP   (S_AXI_BRESP),
  .HYST_OUT      (HYST_OUT),
  .BLANK_OUT     (BLANK_OUT),
  .BRIDGE        (BRIDGE)
);

// file: hysteresis_current_chopper_tb_top.sv
// self-checking testbench for the hysteresis current chopper
`timescale 1ns/10ps
module hysteresis_current_chopper_tb_top;
  logic                 clk, rst, awv, wv, bre, arv, rre, cmp, awr, wr, bv, arr, rv, blank;
  logic [7:0]           awa, ara;
  logic [31:0]          wd, rd;
  logic [3:0]           ws, rate;
  logic [1:0]           br, rr;
  logic [5:0]           hyst;
  hcc_pkg::hcc_bridge_t bridge;
  int                   miscompares, tests_run;
  int                   blens[4] = '{16, 24, 36, 54};

  hcc_chopper u_hcc_chopper (.CLOCK(clk), .RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre),
    .CMP_IN(cmp), .HYST_OUT(hyst), .BLANK_OUT(blank), .BRIDGE(bridge));
  hcc_coil_model u_hcc_coil_model (.CLOCK(clk), .RST(rst), .BRIDGE(bridge), .RATE(rate), .HYST(hyst),
    .CMP_IN(cmp));

  // ==========================================================
  // shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run

  task automatic timeout();
    miscompares++;
    $display("wrong value at %0t: wait ran out", $time);
    complete_run();
  endtask : timeout

  // sample well after the edge so design updates have landed
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  // write both channels together, release each when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
    int n;
    @(posedge clk);
    {awa, wd, ws, awv, wv, bre} <= {a, d, 4'hF, 3'h7};
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) break;
    end
    bre <= 1'b0;
    if (n == 50) timeout();
    check(br, exp);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rexp);
    int n;
    logic [31:0] d;
    @(posedge clk);
    {ara, arv, rre} <= {a, 2'h3};
    for (n = 0; n < 50 && !rv; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      d = rd;
    end
    rre <= 1'b0;
    if (n == 50) timeout();
    check(d, exp);
    check(rr, rexp);
  endtask : axi_rd

  // wait for the bridge to leave one phase, check the next and the time spent
  task automatic next_ph(input logic [2:0] from, input logic [2:0] to, input int len);
    int n;
    #1;
    for (n = 0; n < 3000 && bridge === from; n++) tick();
    if (n == 3000) timeout();
    check(bridge, to);
    if (len > 0) check(n, len);
  endtask : next_ph

  task automatic stop();
    int k;
    axi_wr(hcc_pkg::ADDR_CONF, 32'h0, hcc_pkg::RESP_OKAY);
    for (k = 0; k < 8 && bridge !== 3'h0; k++) tick();
    check(bridge, 3'h0);
  endtask : stop

  // ==========================================================
  // scenarios
  task automatic sc_regs();
    axi_rd(hcc_pkg::ADDR_CONF, hcc_pkg::CONF_RST, hcc_pkg::RESP_OKAY);
    check(bridge, 3'h0);
    axi_wr(hcc_pkg::ADDR_CONF, 32'hFFFF_FFF0, hcc_pkg::RESP_OKAY);
    axi_rd(hcc_pkg::ADDR_CONF, 32'h0000_3FF0, hcc_pkg::RESP_OKAY);
    check(bridge, 3'h0);
    axi_wr(8'h40, 32'h1, hcc_pkg::RESP_SLVERR);
    axi_rd(8'h40, 32'h0, hcc_pkg::RESP_SLVERR);
    axi_wr(hcc_pkg::ADDR_STAT, 32'h1, hcc_pkg::RESP_OKAY);
    axi_rd(hcc_pkg::ADDR_STAT, 32'h0, hcc_pkg::RESP_OKAY);
  endtask : sc_regs

  // master slow to take answers: response and read data must stand until ready
  task automatic sc_hold();
    int n;
    @(posedge clk);
    {awa, wd, ws, awv, wv} <= {hcc_pkg::ADDR_CONF, 32'h0000_2A50, 4'hF, 2'h3};
    for (n = 0; n < 50 && !bv; n++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end
    if (n == 50) timeout();
    repeat (3) @(posedge clk);
    bre <= 1'b1;
    @(posedge clk);
    bre <= 1'b0;
    check(bv, 1'b1);
    check(br, hcc_pkg::RESP_OKAY);
    {ara, arv} <= {hcc_pkg::ADDR_CONF, 1'b1};
    for (n = 0; n < 50 && !rv; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end
    if (n == 50) timeout();
    repeat (3) @(posedge clk);
    rre <= 1'b1;
    @(posedge clk);
    rre <= 1'b0;
    check(rv, 1'b1);
    check(rd, 32'h0000_2A50);
    check(bridge, 3'h0);
  endtask : sc_hold

  // one full cycle, hysteresis and blanking checked at the second on entry
  task automatic sc_cycle(input logic [3:0] t, input logic [2:0] s, input logic [3:0] e, input logic [1:0] b,
                          input logic [3:0] r);
    logic [5:0] h;
    logic [5:0] h20;
    logic [5:0] he;
    int         k;
    int         sl;
    he = (s == 3'h0 && e == 4'h0) ? 6'h00 : {2'h0, e} - 6'h03;
    h = (s == 3'h0 && e == 4'h0) ? 6'h00 : he + {3'h0, s} + 6'h01;
    sl = 12 + 32 * t;
    h20 = 6'h00;
    @(posedge clk);
    rate <= r;
    axi_wr(hcc_pkg::ADDR_CONF, {18'h0, b, 1'b0, e, s, t}, hcc_pkg::RESP_OKAY);
    next_ph(3'h0, 3'h4, 0);
    next_ph(3'h4, 3'h2, 0);
    next_ph(3'h2, 3'h1, sl);
    check(hyst, he);
    next_ph(3'h1, 3'h2, 0);
    next_ph(3'h2, 3'h4, sl);
    check(hyst, h);
    for (k = 0; k < 100 && blank === 1'b1; k++) begin
      if (k == 20) h20 = hyst;
      tick();
    end
    check(k, blens[b]);
    if (b != 2'h0) check(h20, (h == 6'h00) ? h : h - 6'h01);
    stop();
  endtask : sc_cycle

  task automatic sc_mode();
    axi_wr(hcc_pkg::ADDR_CONF, {18'h0, 2'h1, 1'b1, 4'h0, 3'h0, 4'h2}, hcc_pkg::RESP_OKAY);
    next_ph(3'h0, 3'h4, 0);
    next_ph(3'h4, 3'h1, 0);
    stop();
  endtask : sc_mode

  // ==========================================================
  // clock, reset and main sequence
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    {awv, wv, bre, arv, rre} = 5'h00;
    {awa, ara, wd, ws} = '0;
    rate = 4'h1;
    {miscompares, tests_run} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    sc_regs();
    sc_hold();
    sc_cycle(4'h1, 3'h0, 4'h0, 2'h1, 4'h1);
    sc_cycle(4'hF, 3'h7, 4'h9, 2'h3, 4'h4);
    sc_cycle(4'h4, 3'h3, 4'h0, 2'h2, 4'h2);
    sc_cycle(4'h2, 3'h0, 4'h6, 2'h0, 4'h1);
    sc_mode();
    complete_run();
  end
endmodule : hysteresis_current_chopper_tb_top
